// ---- verilog/ccs_consts.svh ----
// constant definitions for the card configuration and status register block
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH
// ****************************************
// attribute register offsets
// ****************************************
`define CCS_OFS_OPTION      11'h200
`define CCS_OFS_CFG_STATUS  11'h202
`define CCS_OFS_PIN_SUBST   11'h204
`define CCS_OFS_SOCKET_COPY 11'h206
// ****************************************
// field positions
// ****************************************
`define CCS_OPT_SRST_BIT    7
`define CCS_OPT_LEVEL_BIT   6
`define CCS_CS_CHANGE_BIT   7
`define CCS_CS_SIGEN_BIT    6
`define CCS_CS_EIGHT_BIT    5
`define CCS_CS_PWD_BIT      2
`define CCS_CS_INTERRUPT_STATUS_BIT_BIT     1
`define CCS_PS_CHG_BIT      5
`define CCS_PS_RDY_BIT      1
`define CCS_SC_DRV_BIT      4
// fixed bits of the pin substitute register (bits 3 and 2 read one)
`define CCS_PS_FIXED        8'h0c
// ****************************************
// reset values and mode-select codes
// ****************************************
`define CCS_RESET_BYTE      8'h00
`define CCS_MODE_MEMORY     6'h00
`define CCS_MODE_CONTIG     6'h01
`define CCS_MODE_PRIMARY    6'h02
`define CCS_MODE_SECONDARY  6'h03
// ****************************************
// task-file windows
// ****************************************
`define CCS_MEM_TF_LO_END   11'h00f
`define CCS_MEM_TF_HI_BASE  11'h400
`define CCS_MEM_TF_HI_END   11'h7ff
`define CCS_PRI_BASE        11'h1f0
`define CCS_PRI_END         11'h1f7
`define CCS_PRI_ALT_BASE    11'h3f6
`define CCS_PRI_ALT_END     11'h3f7
`define CCS_SEC_BASE        11'h170
`define CCS_SEC_END         11'h177
`define CCS_SEC_ALT_BASE    11'h376
`define CCS_SEC_ALT_END     11'h377
// ****************************************
// timing
// ****************************************
`define CCS_CLK_PERIOD_NS   100
`define CCS_PWR_SETTLE_NS   1000
`define CCS_PWR_SETTLE_CYC  ((`CCS_PWR_SETTLE_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS)
`endif

// ---- verilog/ccs_pkg.sv ----
// types for the card configuration and status register block
package ccs_pkg;
	// power sequencing states
	typedef enum logic [2:0] {
		CCS_PWR_ACTIVE   = 3'b001,
		CCS_PWR_SETTLING = 3'b010,
		CCS_PWR_ASLEEP   = 3'b100
	} ccs_pwr_t;

	// all state of the register block
	typedef struct packed {
		logic [25:0] pin1;
		logic [25:0] pin2;
		logic        we_d;
		logic [5:0]  mode_select;
		logic        level_irq;
		logic        soft_reset;
		logic        status_change_enable;
		logic        eight_bit_host_flag;
		logic        power_down_bit;
		logic        ready_busy_change_latch;
		logic        ready_mask;
		logic        drive_copy_number;
		ccs_pwr_t    pwr;
		logic [3:0]  settle_cnt;
		logic        target_sleep;
		logic        ready;
		logic        status_change_out_n;
		logic [7:0]  dout;
		logic        doe;
		logic        tf_sel;
		logic [3:0]  tf_index;
		logic        slave;
	} ccs_state_t;
endpackage : ccs_pkg

// ---- verilog/ccs_regs.sv ----
// card configuration and status registers with task-file window decode
`timescale 1ns/1ps
`include "ccs_consts.svh"

module ccs_regs (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        reg_n,
	input  wire logic        ce1_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        iord_n,
	input  wire logic        iowr_n,
	input  wire logic        hard_reset,
	input  wire logic [10:0] addr,
	input  wire logic [7:0]  data_in,
	input  wire logic        core_busy,
	input  wire logic        core_idle,
	input  wire logic        command_pulse,
	input  wire logic        interrupt_status_bit_request,
	input  wire logic        interrupt_disable_bit,
	output logic [7:0]       data_out,
	output logic             data_oe,
	output logic             status_change_out_n,
	output logic             ready_out,
	output logic             sleep_state,
	output logic             tf_select,
	output logic [3:0]       tf_index,
	output logic             slave_card,
	output logic             eight_bit_host,
	output logic             level_irq_mode
);
	// ****************************************
	// state
	// ****************************************
	localparam logic [3:0] SETTLE_LAST = 4'(`CCS_PWR_SETTLE_CYC - 1);

	ccs_pkg::ccs_state_t q;
	ccs_pkg::ccs_state_t n;

	// synchronised pin view, second stage only
	logic        s_reg_n;
	logic        s_ce1_n;
	logic        s_oe_n;
	logic        s_we_n;
	logic        s_iord_n;
	logic        s_iowr_n;
	logic        s_hard;
	logic [10:0] s_addr;
	logic [7:0]  s_data;
	logic        clr;
	logic        attr_wr;
	logic        attr_rd;
	logic        io_cycle;
	logic        mem_cycle;
	logic        io_mode;
	logic        ready_live;
	logic        interrupt_status_bit_view;

	assign {s_reg_n, s_ce1_n, s_oe_n, s_we_n, s_iord_n, s_iowr_n, s_hard} = q.pin2[25:19];
	assign s_addr = q.pin2[18:8];
	assign s_data = q.pin2[7:0];

	// access qualifiers from the synchronised pins
	assign clr       = s_hard | q.soft_reset;
	assign attr_wr   = !s_reg_n && !s_ce1_n && s_we_n && !q.we_d;
	assign attr_rd   = !s_reg_n && !s_ce1_n && !s_oe_n;
	assign io_cycle  = !s_reg_n && !s_ce1_n && (!s_iord_n || !s_iowr_n);
	assign mem_cycle = s_reg_n && !s_ce1_n && (!s_oe_n || !s_we_n);
	assign io_mode   = q.mode_select != `CCS_MODE_MEMORY;
	assign ready_live = !core_busy && (q.pwr != ccs_pkg::CCS_PWR_SETTLING);
	assign interrupt_status_bit_view = interrupt_status_bit_request && !interrupt_disable_bit;

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		n = q;
		// two-stage pin synchroniser; stage one feeds stage two only
		n.pin1 = {reg_n, ce1_n, oe_n, we_n, iord_n, iowr_n, hard_reset, addr, data_in};
		n.pin2 = q.pin1;
		n.we_d = s_we_n;

		// host writes land on the release of the write strobe
		if (attr_wr) begin
			unique case (s_addr)
				`CCS_OFS_OPTION: begin
					n.mode_select = s_data[5:0];
					n.level_irq   = s_data[`CCS_OPT_LEVEL_BIT];
					n.soft_reset  = s_data[`CCS_OPT_SRST_BIT];
				end
				`CCS_OFS_CFG_STATUS: begin
					n.status_change_enable = s_data[`CCS_CS_SIGEN_BIT];
					n.eight_bit_host_flag  = s_data[`CCS_CS_EIGHT_BIT];
					n.power_down_bit       = s_data[`CCS_CS_PWD_BIT];
				end
				`CCS_OFS_PIN_SUBST: begin
					n.ready_busy_change_latch = s_data[`CCS_PS_CHG_BIT];
					n.ready_mask              = s_data[`CCS_PS_RDY_BIT];
				end
				`CCS_OFS_SOCKET_COPY: begin
					n.drive_copy_number = s_data[`CCS_SC_DRV_BIT];
				end
				default: begin
					n.we_d = s_we_n; // other offsets are unmapped, writes ignored
				end
			endcase
		end

		// hard or soft reset returns registers to zero; soft bit survives itself
		if (clr) begin
			n.mode_select             = `CCS_MODE_MEMORY;
			n.level_irq               = 1'b0;
			n.status_change_enable    = 1'b0;
			n.eight_bit_host_flag     = 1'b0;
			n.power_down_bit          = 1'b0;
			n.ready_busy_change_latch = 1'b0;
			n.ready_mask              = 1'b0;
			n.drive_copy_number       = 1'b0;
			if (s_hard) begin
				n.soft_reset = 1'b0;
			end
		end

		n.ready = ready_live;

		// power sequencing; any change of the bit restarts the settle wait
		unique case (q.pwr)
			ccs_pkg::CCS_PWR_ACTIVE: begin
				if (core_idle && !command_pulse) begin
					n.pwr = ccs_pkg::CCS_PWR_ASLEEP;
				end
			end
			ccs_pkg::CCS_PWR_SETTLING: begin
				if (q.settle_cnt == 4'h0) begin
					n.pwr = q.target_sleep ? ccs_pkg::CCS_PWR_ASLEEP
					                       : ccs_pkg::CCS_PWR_ACTIVE;
				end else begin
					n.settle_cnt = q.settle_cnt - 4'h1;
				end
			end
			ccs_pkg::CCS_PWR_ASLEEP: begin
				if (command_pulse && !q.power_down_bit) begin
					n.pwr = ccs_pkg::CCS_PWR_ACTIVE;
				end
			end
			default: begin
				n.pwr = ccs_pkg::CCS_PWR_SETTLING;
			end
		endcase
		if (n.power_down_bit != q.power_down_bit) begin
			n.pwr          = ccs_pkg::CCS_PWR_SETTLING;
			n.settle_cnt   = SETTLE_LAST;
			n.target_sleep = n.power_down_bit;
			n.ready        = 1'b0;
		end

		// latch either ready edge, the forced busy included; the set beats a host clear
		if ((n.ready != q.ready) && !q.ready_mask) begin
			n.ready_busy_change_latch = 1'b1;
		end

		// status-change pin, high unless enabled in I/O mode with change flagged
		n.status_change_out_n = !(q.ready_busy_change_latch && q.status_change_enable
		                          && io_mode);

		// attribute register read data
		n.doe  = 1'b0;
		n.dout = `CCS_RESET_BYTE;
		if (attr_rd) begin
			unique case (s_addr)
				`CCS_OFS_OPTION: begin
					n.doe  = 1'b1;
					n.dout = {q.soft_reset, q.level_irq, q.mode_select};
				end
				`CCS_OFS_CFG_STATUS: begin
					n.doe  = 1'b1;
					n.dout = {q.ready_busy_change_latch, q.status_change_enable,
					          q.eight_bit_host_flag, 2'b00, q.power_down_bit,
					          interrupt_status_bit_view, 1'b0};
				end
				`CCS_OFS_PIN_SUBST: begin
					n.doe  = 1'b1;
					n.dout = `CCS_PS_FIXED | {2'b00, q.ready_busy_change_latch, 3'b000,
					                          q.ready, 1'b0};
				end
				`CCS_OFS_SOCKET_COPY: begin
					n.doe  = 1'b1;
					n.dout = {3'b000, q.drive_copy_number, 4'h0};
				end
				default: begin
					n.doe = 1'b0; // unmapped attribute space stays undriven
				end
			endcase
		end

		// task-file window decode per mode-select
		n.tf_sel   = 1'b0;
		n.tf_index = s_addr[3:0];
		unique case (q.mode_select)
			`CCS_MODE_MEMORY: begin
				n.tf_sel = mem_cycle && ((s_addr <= `CCS_MEM_TF_LO_END) ||
				           (s_addr >= `CCS_MEM_TF_HI_BASE));
			end
			`CCS_MODE_CONTIG: begin
				n.tf_sel = io_cycle;
			end
			`CCS_MODE_PRIMARY: begin
				if (s_addr >= `CCS_PRI_BASE && s_addr <= `CCS_PRI_END) begin
					n.tf_sel   = io_cycle;
					n.tf_index = {1'b0, s_addr[2:0]};
				end else if (s_addr >= `CCS_PRI_ALT_BASE && s_addr <= `CCS_PRI_ALT_END) begin
					n.tf_sel   = io_cycle;
					n.tf_index = {3'b111, s_addr[0]};
				end
			end
			`CCS_MODE_SECONDARY: begin
				if (s_addr >= `CCS_SEC_BASE && s_addr <= `CCS_SEC_END) begin
					n.tf_sel   = io_cycle;
					n.tf_index = {1'b0, s_addr[2:0]};
				end else if (s_addr >= `CCS_SEC_ALT_BASE && s_addr <= `CCS_SEC_ALT_END) begin
					n.tf_sel   = io_cycle;
					n.tf_index = {3'b111, s_addr[0]};
				end
			end
			default: begin
				n.tf_sel = 1'b0; // undefined modes decode nothing
			end
		endcase

		// copy number one makes this card the slave
		n.slave = q.drive_copy_number;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q                     <= '0;
			q.pin1                <= 26'h3ffff00;
			q.pin2                <= 26'h3ffff00;
			q.we_d                <= 1'b1;
			q.pwr                 <= ccs_pkg::CCS_PWR_ACTIVE;
			q.status_change_out_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// outputs straight from flops
	assign data_out            = q.dout;
	assign data_oe             = q.doe;
	assign status_change_out_n = q.status_change_out_n;
	assign ready_out           = q.ready;
	assign sleep_state         = q.pwr[2]; // asleep is the top one-hot bit
	assign tf_select           = q.tf_sel;
	assign tf_index            = q.tf_index;
	assign slave_card          = q.slave;
	assign eight_bit_host      = q.eight_bit_host_flag;
	assign level_irq_mode      = q.level_irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_status_change_out_n_drive: assert property (
		(q.ready_busy_change_latch && q.status_change_enable && io_mode) |=> !q.status_change_out_n
	) else $error("status change not driven low");

	a_status_change_out_n_hold: assert property (
		!q.status_change_enable |=> q.status_change_out_n
	) else $error("status change low while disabled");

	a_pwd_busy: assert property (
		$changed(q.power_down_bit) |-> !q.ready ##1 (!q.ready)[*8]
	) else $error("ready during power transition");

	a_chg_latch_set: assert property (
		($changed(q.ready) && !$past(q.ready_mask)) |-> q.ready_busy_change_latch
	) else $error("change latch missed ready edge");

	a_mode_cleared: assert property (
		clr |=> q.mode_select == `CCS_MODE_MEMORY
	) else $error("mode select not cleared by reset");

	a_interrupt_status_bit_masked: assert property (
		(attr_rd && s_addr == `CCS_OFS_CFG_STATUS && interrupt_disable_bit)
		|=> q.doe && !q.dout[`CCS_CS_INTERRUPT_STATUS_BIT_BIT]
	) else $error("interrupt status visible while disabled");

	a_change_mirror: assert property (
		(attr_rd && s_addr == `CCS_OFS_CFG_STATUS)
		|=> q.dout[`CCS_CS_CHANGE_BIT] == $past(q.ready_busy_change_latch)
	) else $error("change flag does not mirror latch");

	a_primary_alt: assert property (
		(io_cycle && q.mode_select == `CCS_MODE_PRIMARY && s_addr == `CCS_PRI_ALT_BASE)
		|=> q.tf_sel && q.tf_index == 4'he
	) else $error("primary alternate port not decoded");

	a_secondary_miss: assert property (
		(q.mode_select == `CCS_MODE_SECONDARY && s_addr == `CCS_PRI_BASE) |=> !q.tf_sel
	) else $error("secondary mode decoded primary port");

	a_slave_copy: assert property (
		(attr_wr && !clr && s_addr == `CCS_OFS_SOCKET_COPY)
		|-> ##2 q.slave == $past(s_data[`CCS_SC_DRV_BIT], 2)
	) else $error("slave output does not follow copy number");

endmodule : ccs_regs

// ---- bench/ccs_host_model.sv ----
// host socket model driving attribute, memory and I/O cycles toward the card
`timescale 1ns/1ps
module ccs_host_model (
	input  wire logic        mclk,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe,
	input  wire logic        tf_select,
	input  wire logic [3:0]  tf_index,
	output logic             reg_n,
	output logic             ce1_n,
	output logic             oe_n,
	output logic             we_n,
	output logic             iord_n,
	output logic             iowr_n,
	output logic [10:0]      addr,
	output logic [7:0]       data_in
);
	// ****************************************
	// bus idle and release
	// ****************************************
	initial begin
		{reg_n, ce1_n, oe_n, we_n, iord_n, iowr_n} = 6'h3f;
		addr = 11'h000;
		data_in = 8'h00;
	end

	// released address and data flip so a stale value can never look valid
	task automatic release_bus();
		@(posedge mclk);
		{reg_n, ce1_n, oe_n, we_n, iord_n, iowr_n} <= 6'h3f;
		addr <= ~addr;
		data_in <= ~data_in;
		repeat (5) @(posedge mclk);
	endtask : release_bus

	// start a cycle: strobe index 0 oe, 1 we, 2 iord
	task automatic start(input logic rn, input int s, input logic [10:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_n <= rn;
		ce1_n <= 1'b0;
		addr <= a;
		data_in <= d;
		oe_n <= (s != 0);
		we_n <= (s != 1);
		iord_n <= (s != 2);
	endtask : start

	// ****************************************
	// attribute space cycles
	// ****************************************
	// address and data held past the rising strobe since the card syncs it
	task automatic attr_write(input logic [10:0] a, input logic [7:0] d);
		start(1'b0, 1, a, d);
		repeat (4) @(posedge mclk);
		we_n <= 1'b1;
		repeat (4) @(posedge mclk);
		release_bus();
	endtask : attr_write

	task automatic attr_read(input logic [10:0] a, output logic [7:0] d, output logic oe);
		start(1'b0, 0, a, 8'h00);
		repeat (6) @(negedge mclk);
		oe = data_oe;
		d = data_out;
		release_bus();
	endtask : attr_read

	// task-file access: memory window or I/O window
	task automatic tf_access(input logic io, input logic [10:0] a, output logic [4:0] hit);
		start(~io, io ? 2 : 0, a, 8'h00);
		repeat (5) @(negedge mclk);
		hit = {tf_select, tf_index};
		release_bus();
	endtask : tf_access
endmodule : ccs_host_model

// ---- bench/ccs_regs_tb.sv ----
// self-checking testbench of the configuration and status registers
`timescale 1ns/1ps
`define CHK(g, e) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("wrong value at %0t got %h exp %h", $time, (g), (e)); \
	end \
end
module ccs_regs_tb;
	logic        mclk;
	logic        resetn;
	logic        hard_reset;
	logic        core_idle;
	logic        command_pulse;
	logic        interrupt_status_bit_request;
	logic        interrupt_disable_bit;
	logic        core_busy;
	logic        level_irq_mode;
	logic        reg_n, ce1_n, oe_n, we_n, iord_n, iowr_n;
	logic [10:0] addr;
	logic [7:0]  data_in, data_out, rd;
	logic        data_oe, oe, status_change_out_n, ready_out, sleep_state;
	logic        tf_select, slave_card, eight_bit_host;
	logic [3:0]  tf_index;
	logic [4:0]  hit;
	int          num_errors = 0;
	int          comparisons = 0;
	// decode table: mode, io, address, hit, index
	logic [27:0] tab [10] = '{28'h0_0_005_1_5, 28'h0_0_40e_1_e, 28'h0_0_010_0_0,
		28'h1_1_2a3_1_3, 28'h2_1_1f2_1_2, 28'h2_1_3f6_1_e, 28'h2_1_175_0_5,
		28'h3_1_177_1_7, 28'h3_1_377_1_f, 28'h3_1_1f0_0_0};

	// ****************************************
	// clock, design and host
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	ccs_regs dut_u (.mclk(mclk), .resetn(resetn), .reg_n(reg_n), .ce1_n(ce1_n),
		.oe_n(oe_n), .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n),
		.hard_reset(hard_reset), .addr(addr), .data_in(data_in), .core_busy(core_busy),
		.core_idle(core_idle), .command_pulse(command_pulse),
		.interrupt_status_bit_request(interrupt_status_bit_request), .interrupt_disable_bit(interrupt_disable_bit),
		.data_out(data_out), .data_oe(data_oe), .status_change_out_n(status_change_out_n),
		.ready_out(ready_out), .sleep_state(sleep_state), .tf_select(tf_select),
		.tf_index(tf_index), .slave_card(slave_card), .eight_bit_host(eight_bit_host),
		.level_irq_mode(level_irq_mode));

	ccs_host_model host_u (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
		.tf_select(tf_select), .tf_index(tf_index), .reg_n(reg_n), .ce1_n(ce1_n),
		.oe_n(oe_n), .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n), .addr(addr),
		.data_in(data_in));

	// ****************************************
	// helpers
	// ****************************************
	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	// bounded wait on 0 sleep, 1 ready, 2 status-change pin
	task automatic wait_for(input int sel, input logic val);
		int   n;
		logic s;
		n = 0;
		s = ~val;
		while (s !== val && n < 300) begin
			@(negedge mclk);
			s = (sel == 0) ? sleep_state : (sel == 1) ? ready_out : status_change_out_n;
			n++;
		end
		`CHK(s, val)
		if (s !== val)
			conclude();
	endtask : wait_for

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{resetn, hard_reset, core_idle, command_pulse} = 4'h0;
		{interrupt_status_bit_request, interrupt_disable_bit, core_busy} = 3'h0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		repeat (30) @(posedge mclk);
		// reset values, fixed bits, unmapped place
		host_u.attr_read(11'h202, rd, oe);
		`CHK(rd & 8'h7f, 8'h00)
		`CHK(oe, 1'b1)
		host_u.attr_read(11'h204, rd, oe);
		`CHK(rd & 8'hdf, 8'h0e)
		host_u.attr_read(11'h208, rd, oe);
		`CHK(oe, 1'b0)
		// change latch written by host, mirrored as change flag
		host_u.attr_write(11'h204, 8'h00);
		host_u.attr_read(11'h202, rd, oe);
		`CHK(rd, 8'h00)
		// a busy pulse drops ready and latches the change
		core_busy <= 1'b1;
		repeat (3) @(posedge mclk);
		`CHK(ready_out, 1'b0)
		core_busy <= 1'b0;
		host_u.attr_read(11'h204, rd, oe);
		`CHK(rd, 8'h2e)
		host_u.attr_write(11'h204, 8'h20);
		host_u.attr_read(11'h202, rd, oe);
		`CHK(rd, 8'h80)
		// status-change pin needs enable and an I/O mode
		host_u.attr_write(11'h202, 8'h40);
		`CHK(status_change_out_n, 1'b1)
		host_u.attr_write(11'h200, 8'h01);
		wait_for(2, 1'b0);
		host_u.attr_write(11'h202, 8'h00);
		wait_for(2, 1'b1);
		// power-down forces busy, sleep reached, change latched
		host_u.attr_write(11'h204, 8'h00);
		host_u.attr_write(11'h202, 8'h04);
		`CHK(ready_out, 1'b0)
		wait_for(1, 1'b1);
		`CHK(sleep_state, 1'b1)
		host_u.attr_read(11'h202, rd, oe);
		`CHK(rd, 8'h84)
		host_u.attr_write(11'h202, 8'h20);
		`CHK(ready_out, 1'b0)
		wait_for(1, 1'b1);
		`CHK(sleep_state, 1'b0)
		`CHK(eight_bit_host, 1'b1)
		// masked latch stays clear across a power change
		host_u.attr_write(11'h204, 8'h02);
		host_u.attr_write(11'h202, 8'h24);
		wait_for(1, 1'b1);
		host_u.attr_read(11'h202, rd, oe);
		`CHK(rd, 8'h24)
		host_u.attr_write(11'h202, 8'h20);
		wait_for(1, 1'b1);
		`CHK(sleep_state, 1'b0)
		// interrupt status and its disable
		@(posedge mclk);
		interrupt_status_bit_request <= 1'b1;
		host_u.attr_read(11'h202, rd, oe);
		`CHK(rd[1], 1'b1)
		interrupt_disable_bit <= 1'b1;
		host_u.attr_read(11'h202, rd, oe);
		`CHK(rd[1], 1'b0)
		{interrupt_status_bit_request, interrupt_disable_bit} <= 2'h0;
		// copy number before option register; fixed bits ignore writes
		host_u.attr_write(11'h206, 8'hff);
		host_u.attr_read(11'h206, rd, oe);
		`CHK(rd, 8'h10)
		`CHK(slave_card, 1'b1)
		// task-file windows of every mode, hits and misses
		for (int i = 0; i < 10; i++) begin
			host_u.attr_write(11'h200, {4'h0, tab[i][27:24]});
			host_u.tf_access(tab[i][20], tab[i][18:8], hit);
			`CHK(hit, tab[i][4:0])
		end
		// idle card sleeps on its own, a command wakes it
		core_idle <= 1'b1;
		wait_for(0, 1'b1);
		@(posedge mclk);
		core_idle <= 1'b0;
		command_pulse <= 1'b1;
		@(posedge mclk);
		command_pulse <= 1'b0;
		wait_for(0, 1'b0);
		// hard reset clears copy number and returns to memory mode
		host_u.attr_write(11'h200, 8'h43);
		`CHK(level_irq_mode, 1'b1)
		hard_reset <= 1'b1;
		repeat (4) @(posedge mclk);
		hard_reset <= 1'b0;
		repeat (30) @(posedge mclk);
		host_u.attr_read(11'h206, rd, oe);
		`CHK(rd, 8'h00)
		host_u.tf_access(1'b0, 11'h005, hit);
		`CHK(hit, 5'h15)
		`CHK(level_irq_mode, 1'b0)
		`CHK(slave_card, 1'b0)
		conclude();
	end
endmodule : ccs_regs_tb
